/* File: logic/zad_decoder.sv */
// Zone address decoder: splits a command address into zone fields and checks access.
module zad_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic is_write,
  input wire logic encrypted,
  input wire logic blk32,
  input wire logic [1:0] zone_sel,
  input wire logic [15:0] addr,
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [7:0] rsp_status,
  output zad_pkg::zad_zone_t rsp_zone,
  output logic [3:0] rsp_slot,
  output logic [3:0] rsp_block,
  output logic [2:0] rsp_offset,
  output logic [8:0] rsp_byte_addr,
  output logic [5:0] rsp_words
);

  // ----------------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------------
  function automatic logic [3:0] blk_field(input logic [15:0] a, input logic [3:0] s);
    logic [3:0] b;
    b = 4'h0;
    if (s < zad_pkg::ZAD_BIG_SLOT) begin
      b = {3'h0, a[zad_pkg::ZAD_BLK_LSB]};
    end else if (s == zad_pkg::ZAD_BIG_SLOT) begin
      b = a[zad_pkg::ZAD_BLK_LSB +: 4];
    end else begin
      b = {2'h0, a[zad_pkg::ZAD_BLK_LSB +: 2]};
    end
    return b;
  endfunction

  // Only the low five (config) or four (OTP) bits reach the fields; the rest is ignored.
  wire logic [2:0] ofs_raw = addr[zad_pkg::ZAD_OFS_LSB +: zad_pkg::ZAD_OFS_W];
  wire logic [3:0] slot = addr[zad_pkg::ZAD_SLOT_LSB +: zad_pkg::ZAD_SLOT_W];
  wire logic [1:0] cfg_blk = addr[zad_pkg::ZAD_CFG_BLK_LSB +: 2];
  wire logic otp_blk = addr[zad_pkg::ZAD_OTP_BLK_LSB];
  wire logic [3:0] data_blk = blk_field(addr, slot);

  // A block transfer always starts at word zero of the block.
  wire logic [2:0] ofs = blk32 ? 3'h0 : ofs_raw;

  // ----------------------------------------------------------------------
  // Range checks per slot class
  // ----------------------------------------------------------------------
  wire logic small_slot = slot < zad_pkg::ZAD_BIG_SLOT;
  wire logic big_slot = slot == zad_pkg::ZAD_BIG_SLOT;

  // The last block of a short slot holds only one or two words, yet a block transfer of it
  // is taken, so that two or three block transfers cover the whole slot.
  wire logic small_ok = (data_blk == 4'h0) ||
    (data_blk == zad_pkg::ZAD_SMALL_LAST_BLK &&
     ofs == zad_pkg::ZAD_SMALL_LAST_OFS);
  wire logic big_ok = data_blk <= zad_pkg::ZAD_BIG_LAST_BLK;
  wire logic mid_ok = (data_blk < zad_pkg::ZAD_MID_LAST_BLK) ||
    (data_blk == zad_pkg::ZAD_MID_LAST_BLK &&
     ofs <= zad_pkg::ZAD_MID_LAST_OFS);
  wire logic range_ok = small_slot ? small_ok : (big_slot ? big_ok : mid_ok);

  // ----------------------------------------------------------------------
  // Permission checks
  // ----------------------------------------------------------------------
  wire logic wr_perm = zad_pkg::ZAD_WRITE_MASK[slot] && !encrypted;
  wire logic rd_perm = zad_pkg::ZAD_READ_MASK[slot];
  wire logic data_perm = is_write ? wr_perm : rd_perm;

  // Config and OTP never take writes; sizes are only word or block by construction.
  wire logic ro_ok = !is_write;

  // Zone classification and the overall verdict.
  wire zad_pkg::zad_zone_t zone =
    (zone_sel == zad_pkg::ZAD_ZSEL_CONFIG) ? zad_pkg::ZAD_ZONE_CONFIG :
    (zone_sel == zad_pkg::ZAD_ZSEL_OTP) ? zad_pkg::ZAD_ZONE_OTP :
    (zone_sel == zad_pkg::ZAD_ZSEL_DATA) ? zad_pkg::ZAD_ZONE_DATA : zad_pkg::ZAD_ZONE_BAD;

  logic [7:0] next_status;
  logic [3:0] next_block;
  logic [8:0] next_byte;

  // Status: a bad zone code is a parse error, a policy or range miss an execution error.
  always_comb begin
    next_status = zad_pkg::ZAD_ST_OK;
    next_block = 4'h0;
    next_byte = 9'h000;
    case (zone)
      zad_pkg::ZAD_ZONE_CONFIG: begin
        next_block = {2'h0, cfg_blk};
        next_byte = {2'h0, cfg_blk, ofs, 2'h0};
        if (!ro_ok) begin
          next_status = zad_pkg::ZAD_ST_EXEC;
        end
      end
      zad_pkg::ZAD_ZONE_OTP: begin
        next_block = {3'h0, otp_blk};
        next_byte = {3'h0, otp_blk, ofs, 2'h0};
        if (!ro_ok) begin
          next_status = zad_pkg::ZAD_ST_EXEC;
        end
      end
      zad_pkg::ZAD_ZONE_DATA: begin
        next_block = data_blk;
        next_byte = {data_blk, ofs, 2'h0};
        if (!range_ok || !data_perm) begin
          next_status = zad_pkg::ZAD_ST_EXEC;
        end
      end
      default: begin
        next_status = zad_pkg::ZAD_ST_PARSE;
      end
    endcase
  end

  wire logic next_ok = next_status == zad_pkg::ZAD_ST_OK;

  // ----------------------------------------------------------------------
  // Registered answer, one cycle after the request
  // ----------------------------------------------------------------------
  // Registering keeps every data output glitch free for the array controller.
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_ok <= 1'b0;
      rsp_status <= 8'h00;
      rsp_zone <= zad_pkg::ZAD_ZONE_CONFIG;
      rsp_slot <= 4'h0;
      rsp_block <= 4'h0;
      rsp_offset <= 3'h0;
      rsp_byte_addr <= 9'h000;
      rsp_words <= 6'h00;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp_ok <= next_ok;
        rsp_status <= next_status;
        rsp_zone <= zone;
        rsp_slot <= (zone == zad_pkg::ZAD_ZONE_DATA) ? slot : 4'h0;
        rsp_block <= next_block;
        rsp_offset <= ofs;
        rsp_byte_addr <= next_byte;
        rsp_words <= !next_ok ? 6'h00 : (blk32 ? 6'h08 : 6'h01);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_req_write_cfg;
    req_valid && is_write && zone_sel != zad_pkg::ZAD_ZSEL_DATA;
  endsequence

  a_cfg_write_refused: assert property (@(posedge clk) disable iff (rst)
    s_req_write_cfg |=> rsp_valid && !rsp_ok && rsp_words == 6'h00)
    else $error("Write to config or OTP zone was accepted.");

  a_encrypted_write: assert property (@(posedge clk) disable iff (rst)
    req_valid && is_write && encrypted |=> !rsp_ok)
    else $error("Encrypted write was accepted.");

  a_write_slots: assert property (@(posedge clk) disable iff (rst)
    rsp_valid && rsp_ok && $past(is_write) && rsp_zone == zad_pkg::ZAD_ZONE_DATA
    |-> rsp_slot inside {4'h6, 4'h8, 4'h9})
    else $error("Write accepted to a slot without write permission.");

  a_read_slots: assert property (@(posedge clk) disable iff (rst)
    rsp_valid && rsp_ok && !$past(is_write) && rsp_zone == zad_pkg::ZAD_ZONE_DATA
    |-> rsp_slot inside {4'h8, 4'hA, 4'hB, 4'hC})
    else $error("Read accepted from a slot without read permission.");

  a_cfg_upper_ignored: assert property (@(posedge clk) disable iff (rst)
    req_valid && zone_sel == zad_pkg::ZAD_ZSEL_CONFIG |=>
    rsp_byte_addr == {2'h0, $past(addr[4:3]),
                      ($past(blk32) ? 3'h0 : $past(addr[2:0])), 2'h0})
    else $error("Config byte address does not follow low five bits.");

  a_small_slot_range: assert property (@(posedge clk) disable iff (rst)
    rsp_valid && rsp_ok && rsp_zone == zad_pkg::ZAD_ZONE_DATA && rsp_slot < 4'h8
    |-> rsp_block == 4'h0 || (rsp_block == 4'h1 && rsp_offset == 3'h0))
    else $error("Out of range access accepted in a small slot.");

  a_big_slot_range: assert property (@(posedge clk) disable iff (rst)
    rsp_valid && rsp_ok && rsp_slot == 4'h8 |-> rsp_block <= 4'hC)
    else $error("Slot 8 block beyond 0xC accepted.");

  a_mid_slot_range: assert property (@(posedge clk) disable iff (rst)
    rsp_valid && rsp_ok && rsp_slot > 4'h8
    |-> rsp_block < 4'h2 || (rsp_block == 4'h2 && rsp_offset <= 3'h1))
    else $error("Out of range access accepted in slots 9 to 15.");

  a_block_offset_zero: assert property (@(posedge clk) disable iff (rst)
    req_valid && blk32 |=> rsp_offset == 3'h0 && (!rsp_ok || rsp_words == 6'h08))
    else $error("Block transfer did not start at offset zero.");

  a_error_no_data: assert property (@(posedge clk) disable iff (rst)
    rsp_valid && !rsp_ok |-> rsp_words == 6'h00 && rsp_status != zad_pkg::ZAD_ST_OK)
    else $error("Refused access still reports data.");

  // ----------------------------------------------------------------------
  // Answer timing, field extraction and positive grants
  // ----------------------------------------------------------------------
  // Every high cycle of req_valid is one request; the answer follows one cycle later.
  a_answer_follows: assert property (@(posedge clk) disable iff (rst)
    req_valid |=> rsp_valid)
    else $error("Request was not answered in the next cycle.");

  // Without a request the strobe must stay low, or the array would see a phantom access.
  a_no_phantom_answer: assert property (@(posedge clk) disable iff (rst)
    !req_valid |=> !rsp_valid)
    else $error("Answer strobe rose without a request.");

  // The unused zone code is a malformed command, not a policy refusal.
  a_bad_zone_parse: assert property (@(posedge clk) disable iff (rst)
    req_valid && zone_sel == 2'h3 |=>
    !rsp_ok && rsp_status == zad_pkg::ZAD_ST_PARSE && rsp_words == 6'h00)
    else $error("Illegal zone code was not reported as a parse error.");

  // The OTP zone reads only bit 3 and the word bits; everything above is ignored.
  a_otp_low_bits: assert property (@(posedge clk) disable iff (rst)
    req_valid && zone_sel == zad_pkg::ZAD_ZSEL_OTP |=>
    rsp_byte_addr == {3'h0, $past(addr[3]),
                      ($past(blk32) ? 3'h0 : $past(addr[2:0])), 2'h0})
    else $error("OTP byte address does not follow low four bits.");

  // Read only zones must still serve reads, whatever the upper address bits hold.
  a_ro_reads_granted: assert property (@(posedge clk) disable iff (rst)
    req_valid && !is_write &&
    (zone_sel == zad_pkg::ZAD_ZSEL_CONFIG || zone_sel == zad_pkg::ZAD_ZSEL_OTP)
    |=> rsp_ok && rsp_status == zad_pkg::ZAD_ST_OK)
    else $error("Read of config or OTP zone was refused.");

  // A word transfer moves exactly one word, never a single byte.
  a_word_count: assert property (@(posedge clk) disable iff (rst)
    req_valid && !blk32 |=> !rsp_ok || rsp_words == 6'h01)
    else $error("Word transfer reports a count other than one.");

  // Data zone fields are checked at the answer, against the address of the request.
  sequence s_data_req;
    req_valid && zone_sel == zad_pkg::ZAD_ZSEL_DATA;
  endsequence

  sequence s_data_answer;
    s_data_req ##1 rsp_valid;
  endsequence

  a_data_slot_field: assert property (@(posedge clk) disable iff (rst)
    s_data_answer |-> rsp_slot == $past(addr[6:3]))
    else $error("Data slot field does not follow address bits 6 to 3.");

  // The block field width depends on the slot class; wider bits must not leak in.
  a_small_block_field: assert property (@(posedge clk) disable iff (rst)
    s_data_answer |-> rsp_slot >= 4'h8 || rsp_block == {3'h0, $past(addr[8])})
    else $error("Small slot block field does not follow address bit 8.");

  a_big_block_field: assert property (@(posedge clk) disable iff (rst)
    s_data_answer |-> rsp_slot != 4'h8 || rsp_block == $past(addr[11:8]))
    else $error("Slot 8 block field does not follow address bits 11 to 8.");

  a_mid_block_field: assert property (@(posedge clk) disable iff (rst)
    s_data_answer |-> rsp_slot <= 4'h8 || rsp_block == {2'h0, $past(addr[9:8])})
    else $error("Upper slot block field does not follow address bits 9 to 8.");

  // Positive grants: a decoder that refuses everything must not pass unnoticed.
  a_clear_write_granted: assert property (@(posedge clk) disable iff (rst)
    req_valid && zone_sel == zad_pkg::ZAD_ZSEL_DATA && is_write && !encrypted &&
    addr[6:3] == 4'h6 && !addr[8] |=> rsp_ok)
    else $error("Clear write to slot 6 block 0 was refused.");

  a_clear_read_granted: assert property (@(posedge clk) disable iff (rst)
    req_valid && zone_sel == zad_pkg::ZAD_ZSEL_DATA && !is_write &&
    addr[6:3] == 4'h8 && addr[11:8] <= 4'hC |=> rsp_ok)
    else $error("Clear read of a valid slot 8 block was refused.");

  // Both blocks of a small slot take a whole block transfer.
  a_whole_block_small: assert property (@(posedge clk) disable iff (rst)
    req_valid && zone_sel == zad_pkg::ZAD_ZSEL_DATA && is_write && !encrypted &&
    blk32 && addr[6:3] == 4'h6 |=> rsp_ok && rsp_words == 6'h08)
    else $error("Block write to slot 6 was refused.");

  // The third block of an upper slot takes a whole block transfer as well.
  a_whole_block_mid: assert property (@(posedge clk) disable iff (rst)
    req_valid && zone_sel == zad_pkg::ZAD_ZSEL_DATA && !is_write && blk32 &&
    addr[6:3] == 4'hA && addr[9:8] <= 2'h2 |=> rsp_ok && rsp_words == 6'h08)
    else $error("Block read of slot 10 was refused.");

endmodule

/* File: logic/zad_pkg.sv */
// Package with zone codes, field positions and slot limits for the zone address decoder.
package zad_pkg;

  // ----------------------------------------------------------------------
  // Zones, zone select codes and status codes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ZAD_ZONE_CONFIG,
    ZAD_ZONE_OTP,
    ZAD_ZONE_DATA,
    ZAD_ZONE_BAD
  } zad_zone_t;

  localparam logic [1:0] ZAD_ZSEL_CONFIG = 2'h0;
  localparam logic [1:0] ZAD_ZSEL_OTP = 2'h1;
  localparam logic [1:0] ZAD_ZSEL_DATA = 2'h2;

  localparam logic [7:0] ZAD_ST_OK = 8'h00;
  localparam logic [7:0] ZAD_ST_PARSE = 8'h03;
  localparam logic [7:0] ZAD_ST_EXEC = 8'h0F;

  // ----------------------------------------------------------------------
  // Address field positions
  // ----------------------------------------------------------------------
  localparam int ZAD_ADDR_W = 16;
  localparam int ZAD_OFS_LSB = 0;
  localparam int ZAD_OFS_W = 3;
  localparam int ZAD_SLOT_LSB = 3;
  localparam int ZAD_SLOT_W = 4;
  localparam int ZAD_BLK_LSB = 8;
  localparam int ZAD_CFG_BLK_LSB = 3;
  localparam int ZAD_OTP_BLK_LSB = 3;

  // ----------------------------------------------------------------------
  // Slot classes, block and offset limits
  // ----------------------------------------------------------------------
  localparam logic [3:0] ZAD_BIG_SLOT = 4'h8;
  localparam logic [3:0] ZAD_SMALL_LAST_BLK = 4'h1;
  localparam logic [2:0] ZAD_SMALL_LAST_OFS = 3'h0;
  localparam logic [3:0] ZAD_BIG_LAST_BLK = 4'hC;
  localparam logic [3:0] ZAD_MID_LAST_BLK = 4'h2;
  localparam logic [2:0] ZAD_MID_LAST_OFS = 3'h1;

  // Clear-text permission masks, bit n for slot n.
  localparam logic [15:0] ZAD_WRITE_MASK = 16'h0340;
  localparam logic [15:0] ZAD_READ_MASK = 16'h1D00;

endpackage

/* File: dv/zad_host.sv */
// Host model that issues decode requests to the zone address decoder.
module zad_host (
  input wire logic clk,
  output logic req_valid,
  output logic is_write,
  output logic encrypted,
  output logic blk32,
  output logic [1:0] zone_sel,
  output logic [15:0] addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // Request driver
  // ----------------------------------------------------------------------
  // Idle bus at time zero.
  initial begin
    {req_valid, is_write, encrypted, blk32, zone_sel, addr} = '0;
  end
  // One request per call; units are a word or a whole block, never a byte.
  task automatic send(input logic w, e, b, input logic [1:0] z, input logic [15:0] a);
    @(negedge clk);
    req_valid = 1'h1;
    is_write = w;
    encrypted = e;
    blk32 = b;
    zone_sel = z;
    addr = a;
    @(negedge clk);
    req_valid = 1'h0;
    addr = ~a; // A stale address is scrambled so the block cannot lean on it.
  endtask
endmodule

/* File: dv/zone_address_decoder_tb_top.sv */
// Self-checking testbench for the zone address decoder.
module zone_address_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic N = 1'h0;
  localparam logic Y = 1'h1;
  localparam logic [7:0] S_OK = zad_pkg::ZAD_ST_OK;
  localparam logic [7:0] S_EX = zad_pkg::ZAD_ST_EXEC;
  logic clk, rst, req_valid, is_write, encrypted, blk32, rsp_valid, rsp_ok;
  logic [1:0] zone_sel;
  logic [15:0] addr;
  logic [7:0] rsp_status;
  zad_pkg::zad_zone_t rsp_zone;
  logic [3:0] rsp_slot, rsp_block;
  logic [2:0] rsp_offset;
  logic [8:0] rsp_byte_addr;
  logic [5:0] rsp_words;
  int miscompares = 0;
  int n_checks = 0;
  zad_host zad_host_inst (.clk, .req_valid, .is_write, .encrypted, .blk32, .zone_sel, .addr);
  zad_decoder zad_decoder_inst (.clk, .rst, .req_valid, .is_write, .encrypted, .blk32,
    .zone_sel, .addr, .rsp_valid, .rsp_ok, .rsp_status, .rsp_zone, .rsp_slot, .rsp_block,
    .rsp_offset, .rsp_byte_addr, .rsp_words);
  // ----------------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------------
  task automatic cmp(input string n, input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // Fields are only meaningful on an accepted access, so a refusal checks only valid, ok, status and a zero word count.
  task automatic run(input logic w, e, b, input logic [1:0] z, input logic [15:0] a,
    input logic ok, input logic [7:0] st, input logic [3:0] sl, bk, input logic [2:0] of);
    zad_host_inst.send(w, e, b, z, a);
    // The answer rose at the edge that took the request and stands until the next edge,
    // so it is judged at the falling edge on which send returns.
    cmp("valid", 9'h1, {8'h0, rsp_valid});
    cmp("ok", {8'h0, ok}, {8'h0, rsp_ok});
    cmp("status", {1'h0, st}, {1'h0, rsp_status});
    cmp("words", ok ? (b ? 9'h8 : 9'h1) : 9'h0, {3'h0, rsp_words});
    if (ok) begin
      cmp("zone", {7'h0, z}, {7'h0, rsp_zone});
      cmp("slot", {5'h0, sl}, {5'h0, rsp_slot});
      cmp("block", {5'h0, bk}, {5'h0, rsp_block});
      cmp("offset", {6'h0, of}, {6'h0, rsp_offset});
      cmp("byte", {bk, 5'h0} + {4'h0, of, 2'h0}, rsp_byte_addr);
    end
    @(posedge clk);
    #1;
    cmp("pulse", 9'h0, {8'h0, rsp_valid});
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic cfg_otp_zones;
    run(N, N, N, 2'h0, 16'hFFFF, Y, S_OK, 4'h0, 4'h3, 3'h7);
    run(N, N, Y, 2'h0, 16'h001D, Y, S_OK, 4'h0, 4'h3, 3'h0);
    run(Y, N, N, 2'h0, 16'h0000, N, S_EX, 4'h0, 4'h0, 3'h0);
    run(N, N, N, 2'h1, 16'hFFFF, Y, S_OK, 4'h0, 4'h1, 3'h7);
    run(N, N, Y, 2'h1, 16'h000F, Y, S_OK, 4'h0, 4'h1, 3'h0);
    run(Y, N, Y, 2'h1, 16'h0000, N, S_EX, 4'h0, 4'h0, 3'h0);
  endtask
  // Every slot is read, written and written encrypted at block 0, offset 0.
  task automatic data_permissions;
    for (int s = 0; s < 16; s++) begin
      logic rd;
      logic wr;
      rd = s inside {8, 10, 11, 12};
      wr = s inside {6, 8, 9};
      run(N, N, N, 2'h2, {9'h0, s[3:0], 3'h0}, rd, rd ? S_OK : S_EX, s[3:0], 4'h0, 3'h0);
      run(Y, N, N, 2'h2, {9'h0, s[3:0], 3'h0}, wr, wr ? S_OK : S_EX, s[3:0], 4'h0, 3'h0);
      run(Y, Y, N, 2'h2, {9'h0, s[3:0], 3'h0}, N, S_EX, s[3:0], 4'h0, 3'h0);
    end
  endtask
  task automatic data_ranges;
    run(N, N, N, 2'h2, 16'h0C47, Y, S_OK, 4'h8, 4'hC, 3'h7);
    run(N, N, Y, 2'h2, 16'h0C45, Y, S_OK, 4'h8, 4'hC, 3'h0);
    run(N, N, N, 2'h2, 16'h0D40, N, S_EX, 4'h8, 4'h0, 3'h0);
    run(N, N, N, 2'h2, 16'h0251, Y, S_OK, 4'hA, 4'h2, 3'h1);
    run(N, N, N, 2'h2, 16'h0252, N, S_EX, 4'hA, 4'h0, 3'h0);
    run(Y, N, N, 2'h2, 16'h0130, Y, S_OK, 4'h6, 4'h1, 3'h0);
    run(Y, N, N, 2'h2, 16'h0131, N, S_EX, 4'h6, 4'h0, 3'h0);
    run(Y, N, Y, 2'h2, 16'h0130, Y, S_OK, 4'h6, 4'h1, 3'h0);
    run(N, N, Y, 2'h2, 16'h0253, Y, S_OK, 4'hA, 4'h2, 3'h0);
    run(N, N, N, 2'h3, 16'h0000, N, zad_pkg::ZAD_ST_PARSE, 4'h0, 4'h0, 3'h0);
  endtask
  // A mid-run reset must clear the held valid, status, zone, byte address and word count before the next request.
  task automatic reset_check;
    @(negedge clk);
    rst = 1'h1;
    @(negedge clk);
    cmp("rst valid", 9'h0, {8'h0, rsp_valid});
    cmp("rst status", 9'h0, {1'h0, rsp_status});
    cmp("rst zone", 9'h0, {7'h0, rsp_zone});
    cmp("rst byte", 9'h0, rsp_byte_addr);
    cmp("rst words", 9'h0, {3'h0, rsp_words});
    rst = 1'h0;
    run(N, N, N, 2'h2, 16'h0040, Y, S_OK, 4'h8, 4'h0, 3'h0);
  endtask
  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Free-running clock at 25 MHz.
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // Hang guard: the full run needs far fewer cycles than this bound.
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
  // Main sequence: reset for 20 cycles, then the scenarios.
  initial begin
    rst = 1'h1;
    repeat (20) @(negedge clk);
    rst = 1'h0;
    cfg_otp_zones();
    data_permissions();
    data_ranges();
    reset_check();
    tally_and_finish();
  end
endmodule
